/* File: afr_pkg.sv */
// Shared constants and state types for the drive-channel register slice
package afr_pkg;

	// ****************************************
	// Register offsets on the target link
	// ****************************************
	localparam logic [7:0] OFS_EE_DATA  = 8'h5c;
	localparam logic [7:0] OFS_PORT_A   = 8'h60;
	localparam logic [7:0] OFS_PTR01_A  = 8'h68;
	localparam logic [7:0] OFS_PTR23_A  = 8'h6c;
	localparam logic [7:0] OFS_PORT_B   = 8'h70;
	localparam logic [7:0] OFS_PTR01_B  = 8'h78;
	localparam logic [7:0] OFS_PTR23_B  = 8'h7c;
	localparam logic [7:0] OFS_TF0      = 8'h80;
	localparam logic [7:0] OFS_TF1      = 8'h84;

	// ****************************************
	// FIFO geometry and reset values
	// ****************************************
	localparam int         CHANNELS    = 2;
	localparam int         LANES       = 4;
	localparam int         DEPTH       = 64;
	localparam int         PTR_W       = 7;
	localparam logic [6:0] DEPTH_PTR   = 7'h40;
	localparam logic [7:0] EE_RESET    = 8'h00;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// ****************************************
	// Byte enable patterns
	// ****************************************
	localparam logic [3:0] BE_B0   = 4'h1;
	localparam logic [3:0] BE_B1   = 4'h2;
	localparam logic [3:0] BE_B2   = 4'h4;
	localparam logic [3:0] BE_B3   = 4'h8;
	localparam logic [3:0] BE_HALF = 4'h3;
	localparam logic [3:0] BE_WORD = 4'hf;

	// ****************************************
	// Drive register numbers and access sizes
	// ****************************************
	localparam logic [2:0] TF_DATA    = 3'h0;
	localparam logic [2:0] TF_ERRFEAT = 3'h1;
	localparam logic [2:0] TF_SECCNT  = 3'h2;
	localparam logic [2:0] TF_SECNUM  = 3'h3;
	localparam logic [2:0] TF_CYLLO   = 3'h4;
	localparam logic [2:0] TF_CYLHI   = 3'h5;
	localparam logic [2:0] TF_DEVHEAD = 3'h6;
	localparam logic [2:0] TF_CMDSTAT = 3'h7;
	localparam logic [1:0] SZ_8       = 2'h0;
	localparam logic [1:0] SZ_16      = 2'h1;
	localparam logic [1:0] SZ_32      = 2'h2;

	// ****************************************
	// Controller registers on APB
	// ****************************************
	localparam logic [7:0] H_CMD    = 8'h00;
	localparam logic [7:0] H_WDATA  = 8'h04;
	localparam logic [7:0] H_CTRL   = 8'h08;
	localparam logic [7:0] H_STATUS = 8'h0c;
	localparam logic [7:0] H_RDATA  = 8'h10;
	localparam int         CMD_BE_LSB = 8;
	localparam int         CMD_WE_BIT = 16;
	localparam int         ST_BUSY    = 0;
	localparam int         ST_DONE    = 1;
	localparam int         ST_ABORT   = 2;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [1:0] {
		DST_IDLE  = 2'b01,
		DST_DRIVE = 2'b10
	} afr_dst_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b01,
		HST_WAIT = 2'b10
	} afr_hst_t;

	typedef struct packed {
		afr_dst_t                                st;
		logic                                    ack;
		logic                                    abort;
		logic [31:0]                             rdata;
		logic [7:0]                              ee_byte;
		logic                                    drv_req;
		logic                                    drv_we;
		logic [2:0]                              drv_reg;
		logic [1:0]                              drv_size;
		logic [1:0]                              drv_lane;
		logic [31:0]                             drv_wdata;
		logic [1:0][3:0][6:0]                    wptr;
		logic [1:0][3:0][6:0]                    rptr;
		logic [1:0][3:0][63:0][7:0]              mem;
		logic [1:0][31:0]                        side_rdata;
	} afr_dev_state_t;

	typedef struct packed {
		afr_hst_t    st;
		logic        req;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic        we;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        done;
		logic        abort;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} afr_host_state_t;

endpackage

/* File: afr_link_if.sv */
// Target access link between the bus controller and the register slice
`timescale 1ns/1ps
interface afr_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	logic        req;
	logic        we;
	logic [7:0]  addr;
	logic [3:0]  be;
	logic [31:0] wdata;
	logic        ack;
	logic        abort;
	logic [31:0] rdata;

	modport dev (
		input  pclk, presetn, req, we, addr, be, wdata,
		output ack, abort, rdata
	);
	modport host (
		input  pclk, presetn, ack, abort, rdata,
		output req, we, addr, be, wdata
	);
endinterface

/* File: afr_dev.sv */
// Register slice: serial memory byte, channel FIFOs, drive task file
`timescale 1ns/1ps
module afr_dev (
	afr_link_if.dev                 link,
	output logic [7:0]              ee_write_byte,
	input  wire logic               ee_read_valid,
	input  wire logic [7:0]         ee_read_byte,
	input  wire logic               first_channel_transfer_engine_active,
	input  wire logic               second_channel_transfer_engine_active,
	input  wire logic               first_channel_fifo_reset,
	input  wire logic               second_channel_fifo_reset,
	input  wire logic [1:0][3:0]    side_push,
	input  wire logic [1:0][3:0]    side_pop,
	input  wire logic [1:0][31:0]   side_wdata,
	output logic [1:0][31:0]        side_rdata,
	output logic                    drv_req,
	output logic                    drv_we,
	output logic [2:0]              drv_reg,
	output logic [1:0]              drv_size,
	output logic [31:0]             drv_wdata,
	input  wire logic               drv_ack,
	input  wire logic [31:0]        drv_rdata
);

	// ****************************************
	// State
	// ****************************************
	afr_pkg::afr_dev_state_t s;
	afr_pkg::afr_dev_state_t n;
	logic [1:0]              busy;
	logic [1:0]              frst;

	assign busy = {second_channel_transfer_engine_active,
		first_channel_transfer_engine_active};
	assign frst = {second_channel_fifo_reset, first_channel_fifo_reset};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [1:0][3:0] p_push;
		logic [1:0][3:0] p_pop;
		logic [1:0]      p_any;
		logic            ch;
		logic            tf_ok;
		logic [2:0]      tf_reg;
		logic [1:0]      tf_size;
		logic [1:0]      tf_lane;
		logic            full;
		logic            empty;
		logic            take;
		n       = s;
		p_push  = '0;
		p_pop   = '0;
		p_any   = '0;
		ch      = 1'b0;
		tf_ok   = 1'b1;
		tf_reg  = afr_pkg::TF_DATA;
		tf_size = afr_pkg::SZ_8;
		tf_lane = 2'h0;
		full    = 1'b0;
		empty   = 1'b0;
		take    = link.req && !s.ack && (s.st == afr_pkg::DST_IDLE);
		n.ack   = 1'b0;
		n.abort = 1'b0;

		// Task file decode; field comes from the enables, width too at TF0 (TF1 is byte only)
		if (link.addr == afr_pkg::OFS_TF0) begin
			case (link.be)
				afr_pkg::BE_B0: tf_size = afr_pkg::SZ_8;
				afr_pkg::BE_HALF: tf_size = afr_pkg::SZ_16;
				afr_pkg::BE_WORD: tf_size = afr_pkg::SZ_32;
				afr_pkg::BE_B1: begin
					tf_reg  = afr_pkg::TF_ERRFEAT;
					tf_lane = 2'h1;
				end
				afr_pkg::BE_B2: begin
					tf_reg  = afr_pkg::TF_SECCNT;
					tf_lane = 2'h2;
				end
				afr_pkg::BE_B3: begin
					tf_reg  = afr_pkg::TF_SECNUM;
					tf_lane = 2'h3;
				end
				default: tf_ok = 1'b0;
			endcase
		end else begin
			case (link.be)
				afr_pkg::BE_B0: tf_reg = afr_pkg::TF_CYLLO;
				afr_pkg::BE_B1: begin
					tf_reg  = afr_pkg::TF_CYLHI;
					tf_lane = 2'h1;
				end
				afr_pkg::BE_B2: begin
					tf_reg  = afr_pkg::TF_DEVHEAD;
					tf_lane = 2'h2;
				end
				afr_pkg::BE_B3: begin
					tf_reg  = afr_pkg::TF_CMDSTAT;
					tf_lane = 2'h3;
				end
				default: tf_ok = 1'b0;
			endcase
		end

		case (s.st)
			afr_pkg::DST_IDLE: begin
				if (take) begin
					n.ack   = 1'b1;
					n.rdata = afr_pkg::ZERO_WORD;
					case (link.addr)
						afr_pkg::OFS_EE_DATA: begin
							if (link.we && link.be[0])
								n.ee_byte = link.wdata[7:0];
							n.rdata = 32'(s.ee_byte);
						end
						afr_pkg::OFS_PORT_A,
						afr_pkg::OFS_PORT_B: begin
							ch = (link.addr == afr_pkg::OFS_PORT_B);
							if (link.we) begin
								p_push[ch] = link.be;
								p_any[ch]  = 1'b1;
							end else if (busy[ch]) begin
								n.abort = 1'b1;
							end else begin
								p_pop[ch] = link.be;
								p_any[ch] = 1'b1;
								for (int l = 0; l < afr_pkg::LANES; l++) begin
									if (link.be[l] &&
										s.wptr[ch][l] != s.rptr[ch][l])
										n.rdata[8*l +: 8] = s.mem[ch][l]
											[s.rptr[ch][l][5:0]];
								end
							end
						end
						afr_pkg::OFS_PTR01_A,
						afr_pkg::OFS_PTR01_B: begin
							ch = (link.addr == afr_pkg::OFS_PTR01_B);
							n.rdata = {8'(s.wptr[ch][1]), 8'(s.rptr[ch][1]),
								8'(s.wptr[ch][0]), 8'(s.rptr[ch][0])};
						end
						afr_pkg::OFS_PTR23_A,
						afr_pkg::OFS_PTR23_B: begin
							ch = (link.addr == afr_pkg::OFS_PTR23_B);
							n.rdata = {8'(s.wptr[ch][3]), 8'(s.rptr[ch][3]),
								8'(s.wptr[ch][2]), 8'(s.rptr[ch][2])};
						end
						afr_pkg::OFS_TF0,
						afr_pkg::OFS_TF1: begin
							if (tf_ok) begin
								n.ack       = 1'b0;
								n.st        = afr_pkg::DST_DRIVE;
								n.drv_req   = 1'b1;
								n.drv_we    = link.we;
								n.drv_reg   = tf_reg;
								n.drv_size  = tf_size;
								n.drv_lane  = tf_lane;
								n.drv_wdata = link.wdata >> {tf_lane, 3'b000};
							end
						end
						default: n.rdata = afr_pkg::ZERO_WORD;
					endcase
				end
			end
			afr_pkg::DST_DRIVE: begin
				if (drv_ack) begin
					n.drv_req = 1'b0;
					n.ack     = 1'b1;
					n.st      = afr_pkg::DST_IDLE;
					n.rdata   = afr_pkg::ZERO_WORD;
					if (!s.drv_we) begin
						case (s.drv_size)
							afr_pkg::SZ_8: n.rdata = 32'(drv_rdata[7:0])
								<< {s.drv_lane, 3'b000};
							afr_pkg::SZ_16: n.rdata = 32'(drv_rdata[15:0]);
							default: n.rdata = drv_rdata;
						endcase
					end
				end
			end
			default: n.st = afr_pkg::DST_IDLE;
		endcase

		// Fetched byte lands after any software write, so it is never lost
		if (ee_read_valid)
			n.ee_byte = ee_read_byte;

		// A debug port access owns the channel for its cycle; the drive
		// side is held off then rather than racing on the same pointer
		for (int c = 0; c < afr_pkg::CHANNELS; c++) begin
			for (int l = 0; l < afr_pkg::LANES; l++) begin
				full  = 7'(s.wptr[c][l] - s.rptr[c][l]) == afr_pkg::DEPTH_PTR;
				empty = s.wptr[c][l] == s.rptr[c][l];
				if (frst[c]) begin
					n.wptr[c][l] = '0;
					n.rptr[c][l] = '0;
				end else begin
					if ((p_push[c][l] || (!p_any[c] && side_push[c][l]))
						&& !full) begin
						n.mem[c][l][s.wptr[c][l][5:0]] = p_push[c][l] ?
							link.wdata[8*l +: 8] : side_wdata[c][8*l +: 8];
						n.wptr[c][l] = s.wptr[c][l] + 7'h01;
					end
					if ((p_pop[c][l] || (!p_any[c] && side_pop[c][l]))
						&& !empty) begin
						if (!p_pop[c][l])
							n.side_rdata[c][8*l +: 8] =
								s.mem[c][l][s.rptr[c][l][5:0]];
						n.rptr[c][l] = s.rptr[c][l] + 7'h01;
					end
				end
			end
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			s         <= '0;
			s.st      <= afr_pkg::DST_IDLE;
			s.ee_byte <= afr_pkg::EE_RESET;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.ack      = s.ack;
	assign link.abort    = s.abort;
	assign link.rdata    = s.rdata;
	assign ee_write_byte = s.ee_byte;
	assign side_rdata    = s.side_rdata;
	assign drv_req       = s.drv_req;
	assign drv_we        = s.drv_we;
	assign drv_reg       = s.drv_reg;
	assign drv_size      = s.drv_size;
	assign drv_wdata     = s.drv_wdata;

endmodule // afr_dev

/* File: afr_host.sv */
// Bus controller: APB command registers driving the target access link
`timescale 1ns/1ps
module afr_host (
	afr_link_if.host         link,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata
);

	// ****************************************
	// State
	// ****************************************
	afr_pkg::afr_host_state_t s;
	afr_pkg::afr_host_state_t n;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic acc;
		logic idle;
		n    = s;
		acc  = psel && penable && s.pready && pwrite;
		idle = (s.st == afr_pkg::HST_IDLE);

		// Answer one cycle after setup; read data is captured then
		n.pready = psel && !penable;
		if (psel && !penable) begin
			n.pslverr = 1'b0;
			case (paddr)
				afr_pkg::H_CMD: n.prdata = 32'({s.we, 4'h0, s.be, s.addr});
				afr_pkg::H_WDATA: n.prdata = s.wdata;
				afr_pkg::H_CTRL: n.prdata = afr_pkg::ZERO_WORD;
				afr_pkg::H_STATUS: n.prdata = 32'({s.abort, s.done, !idle});
				afr_pkg::H_RDATA: n.prdata = s.rdata;
				default: begin
					n.prdata  = afr_pkg::ZERO_WORD;
					n.pslverr = 1'b1;
				end
			endcase
		end

		// Command fields are frozen while a transfer is in flight
		if (acc && idle) begin
			case (paddr)
				afr_pkg::H_CMD: begin
					n.addr = pwdata[7:0];
					n.be   = pwdata[afr_pkg::CMD_BE_LSB +: 4];
					n.we   = pwdata[afr_pkg::CMD_WE_BIT];
				end
				afr_pkg::H_WDATA: n.wdata = pwdata;
				afr_pkg::H_CTRL: begin
					if (pwdata[0]) begin
						n.req = 1'b1;
						n.st  = afr_pkg::HST_WAIT;
					end
				end
				default: n.st = s.st;
			endcase
		end
		if (acc && paddr == afr_pkg::H_STATUS) begin
			if (pwdata[afr_pkg::ST_DONE])
				n.done = 1'b0;
			if (pwdata[afr_pkg::ST_ABORT])
				n.abort = 1'b0;
		end

		// Completion comes last so it wins over a clear in the same cycle
		case (s.st)
			afr_pkg::HST_IDLE: n.req = n.req;
			afr_pkg::HST_WAIT: begin
				if (link.ack) begin
					n.req   = 1'b0;
					n.st    = afr_pkg::HST_IDLE;
					n.rdata = link.rdata;
					n.done  = 1'b1;
					n.abort = link.abort;
				end
			end
			default: n.st = afr_pkg::HST_IDLE;
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			s    <= '0;
			s.st <= afr_pkg::HST_IDLE;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.req   = s.req;
	assign link.we    = s.we;
	assign link.addr  = s.addr;
	assign link.be    = s.be;
	assign link.wdata = s.wdata;
	assign pready     = s.pready;
	assign pslverr    = s.pslverr;
	assign prdata     = s.prdata;

endmodule // afr_host

/* File: afr_chk.sv */
// Link checker for the drive-channel register slice
`timescale 1ns/1ps
module afr_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        req,
	input wire logic        we,
	input wire logic [7:0]  addr,
	input wire logic [3:0]  be,
	input wire logic [31:0] wdata,
	input wire logic        ack,
	input wire logic        abort,
	input wire logic [31:0] rdata
);
	// ****************************************
	// Link properties
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ack_pulse: assert property (
		ack |=> !ack) else $error("ack held too long");
	a_ack_has_req: assert property (
		ack |-> req) else $error("ack without request");
	a_quick_ack: assert property (
		$rose(req) && addr != afr_pkg::OFS_TF0 && addr != afr_pkg::OFS_TF1
		|-> ##[1:3] ack) else $error("register answer late");
	a_abort_port_rd: assert property (
		abort |-> ack && !we && rdata == 32'h0000_0000 &&
		(addr == afr_pkg::OFS_PORT_A || addr == afr_pkg::OFS_PORT_B))
		else $error("abort outside port read");
	a_ee_high_zero: assert property (
		ack && !we && addr == afr_pkg::OFS_EE_DATA
		|-> rdata[31:8] == 24'h00_0000) else $error("upper bits set");
	a_view_ptr_width: assert property (
		ack && !we && addr[7:5] == 3'b011 && addr[3] == 1'b1
		|-> (rdata & 32'h8080_8080) == 32'h0000_0000)
		else $error("pointer view too wide");
	a_tf_bad_be: assert property (
		ack && !we && addr == afr_pkg::OFS_TF1 && !$onehot(be)
		|-> rdata == 32'h0000_0000) else $error("bad enables read data");
	a_req_hold: assert property (
		req && !ack |=> req && $stable(addr) && $stable(be) && $stable(wdata))
		else $error("request changed before answer");
endmodule // afr_chk

/* File: test_ata_fifo_debug_taskfile_regs.sv */
// Self-checking bench joining the bus controller and the register slice
`timescale 1ns/1ps
module test_ata_fifo_debug_taskfile_regs;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0000_0000;
	logic             pready, pslverr, drv_req, drv_we;
	logic [31:0]      prdata, drv_wdata;
	logic [7:0]       ee_write_byte;
	logic             ee_read_valid = 1'b0;
	logic [7:0]       ee_read_byte = 8'h00;
	logic [1:0]       eng = 2'b00;
	logic [1:0]       fifo_rst = 2'b00;
	logic [1:0][3:0]  side_push = '0;
	logic [1:0][3:0]  side_pop = '0;
	logic [1:0][31:0] side_wdata = '0;
	logic [1:0][31:0] side_rdata;
	logic [2:0]       drv_reg;
	logic [1:0]       drv_size;
	logic             drv_ack = 1'b0;
	logic [31:0]      drv_rdata = 32'h0000_0000;
	logic [31:0]      tf_rd = 32'h0000_0000;
	logic [31:0]      rnd = 32'h0000_002e;
	int               fail_count = 0;
	int               n_checks = 0;
	logic [39:0]      lq_e[$], lq_m[$], dq_e[$], dq_m[$];
	logic [7:0]       rst_a [8] = '{8'h5c, 8'h60, 8'h68, 8'h6c, 8'h70, 8'h78,
		8'h7c, 8'h40};
	// Entry: address low nibble, enables, drive register, size (3 = refused)
	logic [15:0]      tf_tab [12] = '{16'h0100, 16'h0301, 16'h0f02, 16'h0210,
		16'h0420, 16'h0830, 16'h4140, 16'h4250, 16'h4460, 16'h4870,
		16'h0603, 16'h4303};

	always #4 pclk = ~pclk;

	afr_link_if link (.pclk(pclk), .presetn(presetn));
	afr_chk afr_chk_inst (.pclk(link.pclk), .presetn(link.presetn),
		.req(link.req), .we(link.we), .addr(link.addr), .be(link.be),
		.wdata(link.wdata), .ack(link.ack), .abort(link.abort),
		.rdata(link.rdata));
	afr_host afr_host_inst (.link(link.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));
	afr_dev afr_dev_inst (.link(link.dev), .ee_write_byte(ee_write_byte),
		.ee_read_valid(ee_read_valid), .ee_read_byte(ee_read_byte),
		.first_channel_transfer_engine_active(eng[0]),
		.second_channel_transfer_engine_active(eng[1]),
		.first_channel_fifo_reset(fifo_rst[0]),
		.second_channel_fifo_reset(fifo_rst[1]), .side_push(side_push),
		.side_pop(side_pop), .side_wdata(side_wdata), .side_rdata(side_rdata),
		.drv_req(drv_req), .drv_we(drv_we), .drv_reg(drv_reg),
		.drv_size(drv_size), .drv_wdata(drv_wdata), .drv_ack(drv_ack),
		.drv_rdata(drv_rdata));

	// ****************************************
	// Shared tasks
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic give_verdict();
		// Expectations never met by an answer count as mismatches
		fail_count += lq_e.size() + dq_e.size();
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp,
		input logic [39:0] msk);
		n_checks++;
		if ((got & msk) !== (exp & msk)) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Master holds the whole request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			give_verdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic link_op(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		int          n;
		apb(1'b1, afr_pkg::H_WDATA, d, q, e);
		apb(1'b1, afr_pkg::H_CMD, {15'h0000, w, 4'h0, be, a}, q, e);
		apb(1'b1, afr_pkg::H_CTRL, 32'h0000_0001, q, e);
		n = 0;
		do begin
			apb(1'b0, afr_pkg::H_STATUS, 32'h0000_0000, q, e);
			n++;
		end while (q[afr_pkg::ST_DONE] !== 1'b1 && n < 40);
		if (n >= 40) begin
			fail_count++;
			give_verdict();
		end
		apb(1'b1, afr_pkg::H_STATUS, 32'h0000_0006, q, e);
	endtask

	// Note the expected answer, then issue the read
	task automatic rd(input logic [7:0] a, input logic [3:0] be,
		input logic ab, input logic [31:0] exp, input logic [31:0] msk);
		lq_e.push_back({7'h00, ab, exp});
		lq_m.push_back({8'h01, msk});
		link_op(1'b0, a, be, 32'h0000_0000);
	endtask

	// ****************************************
	// Watchers and drive-side responder
	// ****************************************
	always @(posedge pclk) begin
		if (link.ack === 1'b1 && link.we === 1'b0) begin
			if (lq_e.size() == 0) begin
				fail_count++;
				$display("Error at %0t: got %h expected none", $time, link.rdata);
			end else
				chk({7'h00, link.abort, link.rdata}, lq_e.pop_front(), lq_m.pop_front());
		end
	end

	// Answers slowly so the link waits on the drive handshake
	initial forever begin
		@(posedge pclk);
		if (drv_req === 1'b1) begin
			if (dq_e.size() == 0) begin
				fail_count++;
				$display("Error at %0t: got %h expected none", $time, drv_reg);
			end else
				chk({2'b00, drv_we, drv_reg, drv_size, drv_wdata}, dq_e.pop_front(), dq_m.pop_front());
			repeat (2) @(posedge pclk);
			drv_rdata <= tf_rd;
			drv_ack <= 1'b1;
			@(posedge pclk);
			drv_ack <= 1'b0;
			@(posedge pclk);
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] w, x, m, q;
		logic        e;
		logic [15:0] t;
		logic [7:0]  a;
		logic [3:0]  be;
		int          sh;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rst_a[i]) rd(rst_a[i], 4'hf, 1'b0, 32'h0000_0000, 32'hffff_ffff);
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		chk({39'h00_0000_0000, e}, 40'h00_0000_0001, 40'h00_0000_0001);
		w = rnd ^ 32'hffff_ff00;
		rnd = lfsr(rnd);
		link_op(1'b1, 8'h5c, 4'hf, w);
		chk({32'h0000_0000, ee_write_byte}, {32'h0000_0000, w[7:0]}, 40'h00_0000_00ff);
		rd(8'h5c, 4'hf, 1'b0, {24'h00_0000, w[7:0]}, 32'hffff_ffff);
		ee_read_byte <= rnd[7:0];
		ee_read_valid <= 1'b1;
		@(posedge pclk);
		ee_read_valid <= 1'b0;
		rd(8'h5c, 4'hf, 1'b0, {24'h00_0000, ee_read_byte}, 32'hffff_ffff);
		w = rnd;
		x = lfsr(rnd);
		rnd = lfsr(x);
		link_op(1'b1, 8'h60, 4'hf, w);
		link_op(1'b1, 8'h60, 4'hf, x);
		rd(8'h68, 4'hf, 1'b0, 32'h0200_0200, 32'hffff_ffff);
		rd(8'h6c, 4'hf, 1'b0, 32'h0200_0200, 32'hffff_ffff);
		eng <= 2'b01;
		rd(8'h60, 4'hf, 1'b1, 32'h0000_0000, 32'hffff_ffff);
		eng <= 2'b00;
		rd(8'h60, 4'hf, 1'b0, w, 32'hffff_ffff);
		side_pop[0] <= 4'hf;
		@(posedge pclk);
		side_pop[0] <= 4'h0;
		@(posedge pclk);
		chk({8'h00, side_rdata[0]}, {8'h00, x}, 40'h00_ffff_ffff);
		rd(8'h68, 4'hf, 1'b0, 32'h0202_0202, 32'hffff_ffff);
		link_op(1'b1, 8'h70, 4'h1, rnd);
		eng <= 2'b10;
		rd(8'h70, 4'hf, 1'b1, 32'h0000_0000, 32'hffff_ffff);
		eng <= 2'b00;
		rd(8'h78, 4'hf, 1'b0, 32'h0000_0100, 32'hffff_ffff);
		// One push beyond the depth must be refused
		side_push[1] <= 4'h4;
		side_wdata[1] <= rnd;
		repeat (65) @(posedge pclk);
		side_push[1] <= 4'h0;
		rd(8'h7c, 4'hf, 1'b0, 32'h0000_4000, 32'hffff_ffff);
		side_pop[1] <= 4'h4;
		@(posedge pclk);
		side_pop[1] <= 4'h0;
		@(posedge pclk);
		chk({8'h00, side_rdata[1]}, {8'h00, rnd}, 40'h00_00ff_0000);
		fifo_rst <= 2'b11;
		repeat (2) @(posedge pclk);
		fifo_rst <= 2'b00;
		rd(8'h68, 4'hf, 1'b0, 32'h0000_0000, 32'hffff_ffff);
		rd(8'h7c, 4'hf, 1'b0, 32'h0000_0000, 32'hffff_ffff);
		foreach (tf_tab[i]) begin
			t = tf_tab[i];
			a = {4'h8, t[15:12]};
			be = t[11:8];
			sh = 0;
			for (int k = 0; k < 4; k++)
				if (be[k] && t[7:4] != 4'h0)
					sh = 8 * k;
			w = rnd;
			tf_rd = lfsr(rnd);
			rnd = lfsr(tf_rd);
			m = (t[1:0] == afr_pkg::SZ_32) ? 32'hffff_ffff :
				(t[1:0] == afr_pkg::SZ_16) ? 32'h0000_ffff : 32'h0000_00ff;
			if (t[1:0] == 2'h3) begin
				link_op(1'b1, a, be, w);
				rd(a, be, 1'b0, 32'h0000_0000, 32'hffff_ffff);
			end else begin
				dq_e.push_back({3'b001, t[6:4], t[1:0], w >> sh});
				dq_m.push_back({8'hff, m});
				link_op(1'b1, a, be, w);
				dq_e.push_back({3'b000, t[6:4], t[1:0], 32'h0000_0000});
				dq_m.push_back({8'hff, 32'h0000_0000});
				rd(a, be, 1'b0, tf_rd << sh, m << sh);
			end
		end
		give_verdict();
	end
endmodule // test_ata_fifo_debug_taskfile_regs
